// ---- lpc_led_pwm_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lpc_cfg.svh"

module lpc_led_pwm_ctrl
	import lpc_pkg::*;
#(
	parameter int CHANNELS = `LPC_CHANNELS,
	parameter int DIV_LO   = `LPC_DIV_LO,
	parameter int DIV_HI   = `LPC_DIV_HI
)(
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	input  wire logic                  wr_en_i,
	input  wire logic [7:0]            wr_addr_i,
	input  wire logic [7:0]            wr_data_i,
	input  wire logic                  hw_shutdown_n_i,
	output var  logic [CHANNELS-1:0]   led_drive_o,
	output var  logic [2*CHANNELS-1:0] current_scale_o,
	output var  logic                  serial_if_reset_o
);

	if (CHANNELS < 1 || CHANNELS > `LPC_CHANNELS) begin : g_bad_ch
		$error("Channel count out of range");
	end

	typedef struct packed {
		logic                     sd_meta;
		logic                     sd_sync;
		logic                     sd_prev;
		logic                     serial_rst;
		logic                     soft_run;
		logic                     global_off;
		logic                     freq_sel;
		lpc_duty_t [CHANNELS-1:0] pwm_sh;
		lpc_duty_t [CHANNELS-1:0] pwm_act;
		lpc_ctl_t  [CHANNELS-1:0] ctl_sh;
		lpc_ctl_t  [CHANNELS-1:0] ctl_act;
		logic      [CHANNELS-1:0] drive;
	} lpc_state_t;

	// Channel register hit at base plus index
	function automatic logic lpc_hit(input logic [7:0] a,
		input logic [7:0] base, input int idx);
		return a == 8'(base + idx[7:0]);
	endfunction : lpc_hit

	// Trigger register written with the firing value
	function automatic logic lpc_trig(input logic en,
		input logic [7:0] a, input logic [7:0] d, input logic [7:0] target);
		return en && a == target && d == `LPC_TRIGGER;
	endfunction : lpc_trig

	// Register fields back to their defaults, sync flops untouched
	function automatic lpc_state_t lpc_clear(input lpc_state_t s);
		lpc_state_t r;
		r            = s;
		r.soft_run   = `LPC_RST_BIT;
		r.global_off = `LPC_RST_BIT;
		r.freq_sel   = `LPC_RST_BIT;
		r.pwm_sh     = {CHANNELS{`LPC_RST_BYTE}};
		r.pwm_act    = {CHANNELS{`LPC_RST_BYTE}};
		r.ctl_sh     = {CHANNELS{`LPC_RST_SCALE, `LPC_RST_BIT}};
		r.ctl_act    = {CHANNELS{`LPC_RST_SCALE, `LPC_RST_BIT}};
		r.drive      = '0;
		return r;
	endfunction : lpc_clear

	localparam lpc_state_t ST_IDLE = '{
		sd_meta: 1'b1,
		sd_sync: 1'b1,
		sd_prev: 1'b1,
		default: '0
	};
	localparam lpc_state_t ST_RST = lpc_clear(ST_IDLE);

	lpc_state_t          st;
	lpc_state_t          nxt;
	logic                gate;
	logic                upd_hit;
	logic                rst_hit;
	logic [CHANNELS-1:0] live;

	lpc_tb_if tb_if ();

	lpc_pwm_timebase #(
		.DIV_LO (DIV_LO),
		.DIV_HI (DIV_HI)
	) u_timebase (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.tb      (tb_if)
	);

	assign tb_if.freq_sel = st.freq_sel;

	always_comb begin
		nxt     = st;
		upd_hit = lpc_trig(wr_en_i, wr_addr_i, wr_data_i, `LPC_ADDR_UPDATE);
		rst_hit = lpc_trig(wr_en_i, wr_addr_i, wr_data_i, `LPC_ADDR_RESET);
		// Shutdown pin synchroniser and rising edge pulse
		nxt.sd_meta    = hw_shutdown_n_i;
		nxt.sd_sync    = st.sd_meta;
		nxt.sd_prev    = st.sd_sync;
		nxt.serial_rst = st.sd_sync & ~st.sd_prev;
		// Shared enable of all current sources
		gate = st.soft_run & ~st.global_off & st.sd_sync;
		for (int i = 0; i < CHANNELS; i++) begin
			// Channels that must light at the period start
			live[i] = st.ctl_act[i].on & (st.pwm_act[i] != 8'h00);
			nxt.drive[i] = gate & st.ctl_act[i].on
				& (tb_if.count < st.pwm_act[i]);
		end
		// Writes are taken in any shutdown state
		if (wr_en_i) begin
			if (wr_addr_i == `LPC_ADDR_SHUTDOWN) begin
				nxt.soft_run = wr_data_i[`LPC_BIT_SOFT_RUN];
			end
			if (wr_addr_i == `LPC_ADDR_GLOBAL) begin
				nxt.global_off = wr_data_i[`LPC_BIT_GLOBAL_OFF];
			end
			if (wr_addr_i == `LPC_ADDR_FREQ) begin
				nxt.freq_sel = wr_data_i[`LPC_BIT_FREQ_SEL];
			end
			for (int i = 0; i < CHANNELS; i++) begin
				if (lpc_hit(wr_addr_i, `LPC_ADDR_PWM_FIRST, i)) begin
					nxt.pwm_sh[i] = wr_data_i;
				end
				if (lpc_hit(wr_addr_i, `LPC_ADDR_CTRL_FIRST, i)) begin
					nxt.ctl_sh[i].on    = wr_data_i[`LPC_BIT_CH_ON];
					nxt.ctl_sh[i].scale = wr_data_i[`LPC_SCALE_LSB +: 2];
				end
			end
		end
		// Shadow copies go live together
		if (upd_hit) begin
			nxt.pwm_act = st.pwm_sh;
			nxt.ctl_act = st.ctl_sh;
		end
		if (rst_hit) begin
			nxt = lpc_clear(nxt);
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			st <= ST_RST;
		end else begin
			st <= nxt;
		end
	end

	assign led_drive_o       = st.drive;
	assign serial_if_reset_o = st.serial_rst;

	// Scale code per channel goes to the current source
	for (genvar g = 0; g < CHANNELS; g++) begin : g_scale
		assign current_scale_o[2*g +: 2] = st.ctl_act[g].scale;
	end

	default clocking cb @(posedge clk_i);
	endclocking

	default disable iff (reset_i);

	sequence s_ctl0_wr;
		wr_en_i && wr_addr_i == `LPC_ADDR_CTRL_FIRST;
	endsequence

	sequence s_pwm0_wr;
		wr_en_i && wr_addr_i == `LPC_ADDR_PWM_FIRST;
	endsequence

	sequence s_update;
		wr_en_i && wr_addr_i == `LPC_ADDR_UPDATE
			&& wr_data_i == `LPC_TRIGGER;
	endsequence

	sequence s_reset_wr;
		wr_en_i && wr_addr_i == `LPC_ADDR_RESET
			&& wr_data_i == `LPC_TRIGGER;
	endsequence

	sequence s_ch0_live;
		gate && st.ctl_act[0].on && st.pwm_act[0] != 8'h00;
	endsequence

	a_global_dark: assert property (
		st.global_off |=> led_drive_o == '0)
		else $error("Output driven while globally disabled");

	a_freq_follow: assert property (
		wr_en_i && wr_addr_i == `LPC_ADDR_FREQ
		|=> tb_if.freq_sel == $past(wr_data_i[`LPC_BIT_FREQ_SEL]))
		else $error("Frequency select did not follow write");

	a_reset_clear: assert property (
		s_reset_wr |=> !st.soft_run && !st.global_off && !st.freq_sel
			&& st.pwm_sh == '0 && st.pwm_act == '0
			&& st.ctl_sh == '0 && st.ctl_act == '0)
		else $error("Reset register write left a register set");

	a_powerup_dark: assert property (
		@(posedge clk_i) disable iff (1'b0)
		reset_i |-> led_drive_o == '0 && st.pwm_act == '0
			&& st.ctl_act == '0 && !st.soft_run)
		else $error("Registers not at defaults during reset");

	a_duty_start: assert property (
		s_ch0_live and tb_if.count == 8'h00 |=> led_drive_o[0])
		else $error("Channel not on at start of period");

	a_duty_end: assert property (
		gate && tb_if.count == st.pwm_act[0] |=> !led_drive_o[0])
		else $error("Channel still on at its duty step");

	a_duty_zero: assert property (
		st.pwm_act[0] == 8'h00 |=> !led_drive_o[0])
		else $error("Zero duty channel driven");

	a_scale_shadow: assert property (
		s_ctl0_wr |=> $stable(current_scale_o))
		else $error("Scale changed before update");

	a_scale_update: assert property (
		s_ctl0_wr ##1 s_update
		|=> current_scale_o[1:0] == $past(wr_data_i[2:1], 2))
		else $error("Scale not applied by update");

	a_pwm_update: assert property (
		s_pwm0_wr ##1 s_update |=> st.pwm_act[0] == $past(wr_data_i, 2))
		else $error("Duty not applied by update");

	a_regs_hold: assert property (
		!wr_en_i |=> $stable(st.pwm_sh) && $stable(st.pwm_act)
			&& $stable(st.ctl_act) && $stable(st.soft_run))
		else $error("Register changed without a write");

	a_soft_dark: assert property (
		!st.soft_run |=> led_drive_o == '0)
		else $error("Output driven in software shutdown");

	a_pin_dark: assert property (
		!hw_shutdown_n_i [*3] |=> led_drive_o == '0)
		else $error("Output driven in hardware shutdown");

	a_chan_off: assert property (
		!st.ctl_act[0].on |=> !led_drive_o[0])
		else $error("Channel driven while switched off");

	a_serial_pulse: assert property (
		$rose(hw_shutdown_n_i) |-> ##3 serial_if_reset_o ##1 !serial_if_reset_o)
		else $error("Serial reset pulse missing after pin rise");

	a_wake_keeps: assert property (
		$rose(st.sd_sync) && !wr_en_i |=> $stable(st.pwm_act)
			&& $stable(st.ctl_act))
		else $error("Registers lost on shutdown release");

	a_common_start: assert property (
		tb_if.count == 8'h00 && gate |=> led_drive_o == $past(live))
		else $error("Channels did not start on shared boundary");

	a_drive_needs_all: assert property (
		led_drive_o[0] |-> $past(gate) && $past(st.ctl_act[0].on))
		else $error("Channel driven without every enable");

	a_scale_hold: assert property (
		!(wr_en_i && wr_data_i == `LPC_TRIGGER
			&& (wr_addr_i == `LPC_ADDR_UPDATE
			|| wr_addr_i == `LPC_ADDR_RESET))
		|=> $stable(current_scale_o))
		else $error("Scale changed without update");

	a_update_copy: assert property (
		s_update |=> st.pwm_act == $past(st.pwm_sh)
			&& st.ctl_act == $past(st.ctl_sh))
		else $error("Update did not copy every shadow");

	a_soft_follow: assert property (
		wr_en_i && wr_addr_i == `LPC_ADDR_SHUTDOWN
		|=> st.soft_run == $past(wr_data_i[`LPC_BIT_SOFT_RUN]))
		else $error("Soft-run bit did not follow write");

	a_global_follow: assert property (
		wr_en_i && wr_addr_i == `LPC_ADDR_GLOBAL
		|=> st.global_off == $past(wr_data_i[`LPC_BIT_GLOBAL_OFF]))
		else $error("Global disable did not follow write");

endmodule : lpc_led_pwm_ctrl

`default_nettype wire

// ---- lpc_cfg.svh ----
`ifndef LPC_CFG_SVH
`define LPC_CFG_SVH

// Register offsets
`define LPC_ADDR_SHUTDOWN   8'h00
`define LPC_ADDR_PWM_FIRST  8'h01
`define LPC_ADDR_UPDATE     8'h25
`define LPC_ADDR_CTRL_FIRST 8'h26
`define LPC_ADDR_GLOBAL     8'h4A
`define LPC_ADDR_FREQ       8'h4B
`define LPC_ADDR_RESET      8'h4F

// Data value that fires the update and reset registers
`define LPC_TRIGGER         8'h00

// Field positions
`define LPC_BIT_SOFT_RUN    0
`define LPC_BIT_GLOBAL_OFF  0
`define LPC_BIT_FREQ_SEL    0
`define LPC_BIT_CH_ON       0
`define LPC_SCALE_LSB       1

// Reset values
`define LPC_RST_BIT         1'b0
`define LPC_RST_BYTE        8'h00
`define LPC_RST_SCALE       2'h0

// Channel count and PWM timing
`define LPC_CHANNELS        36
`define LPC_CLK_HZ          125000000
`define LPC_PWM_LO_HZ       3000
`define LPC_PWM_HI_HZ       22000
`define LPC_PWM_STEPS       256
`define LPC_DIV_LO (`LPC_CLK_HZ / (`LPC_PWM_LO_HZ * `LPC_PWM_STEPS))
`define LPC_DIV_HI (`LPC_CLK_HZ / (`LPC_PWM_HI_HZ * `LPC_PWM_STEPS))

`endif

// ---- lpc_pkg.sv ----
package lpc_pkg;

	typedef logic [7:0] lpc_duty_t;

	typedef struct packed {
		logic [1:0] scale;
		logic       on;
	} lpc_ctl_t;

endpackage : lpc_pkg

// ---- lpc_tb_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface lpc_tb_if;
	logic       freq_sel;
	logic       step_en;
	logic [7:0] count;

	modport src (input freq_sel, output step_en, output count);
	modport snk (output freq_sel, input step_en, input count);
endinterface : lpc_tb_if

`default_nettype wire

// ---- lpc_pwm_timebase.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lpc_cfg.svh"

module lpc_pwm_timebase
	import lpc_pkg::*;
#(
	parameter int DIV_LO = `LPC_DIV_LO,
	parameter int DIV_HI = `LPC_DIV_HI
)(
	input  wire logic clk_i,
	input  wire logic reset_i,
	lpc_tb_if.src     tb
);

	localparam int DW  = $clog2(DIV_LO);
	localparam int GAP = DIV_LO;

	if (DIV_HI < 2 || DIV_LO < DIV_HI) begin : g_bad_div
		$error("Divider counts out of range");
	end

	typedef struct packed {
		logic [DW-1:0] div;
		logic [7:0]    count;
		logic          step;
	} lpc_tb_state_t;

	lpc_tb_state_t st;
	lpc_tb_state_t nxt;
	logic [DW-1:0] limit;

	// Step prescaler and shared period counter
	always_comb begin
		nxt = st;
		nxt.step = 1'b0;
		limit = tb.freq_sel ? DW'(DIV_HI - 1) : DW'(DIV_LO - 1);
		if (st.div >= limit) begin
			nxt.div   = '0;
			nxt.step  = 1'b1;
			nxt.count = st.count + 8'h01;
		end else begin
			nxt.div = st.div + DW'(1);
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			st <= '0;
		end else begin
			st <= nxt;
		end
	end

	assign tb.step_en = st.step;
	assign tb.count   = st.count;

	a_step_single: assert property (@(posedge clk_i) disable iff (reset_i)
		tb.step_en |=> !tb.step_en)
		else $error("Step enable longer than one cycle");

	a_step_gap: assert property (@(posedge clk_i) disable iff (reset_i)
		tb.step_en |-> ##[1:GAP] tb.step_en)
		else $error("Step enable missing within slow period");

	a_count_advance: assert property (@(posedge clk_i) disable iff (reset_i)
		!tb.step_en |-> tb.count == $past(tb.count))
		else $error("Period counter moved without a step");

endmodule : lpc_pwm_timebase

`default_nettype wire

// ---- lpc_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lpc_cfg.svh"

module lpc_host_model
	import lpc_pkg::*;
(
	input  wire logic       clk_i,
	output var  logic       wr_en_o,
	output var  logic [7:0] wr_addr_o,
	output var  logic [7:0] wr_data_o,
	output var  logic       hw_shutdown_n_o
);
	// Steps for a one second breathing cycle
	localparam int        GAMMA_STEPS = 32;
	// Lower part of the 32-step gamma curve
	localparam lpc_duty_t G32 [8] = '{8'h00, 8'h01, 8'h02, 8'h04,
		8'h06, 8'h0A, 8'h0D, 8'h12};

	initial begin
		wr_en_o         = 1'b0;
		wr_addr_o       = 8'h00;
		wr_data_o       = 8'h00;
		hw_shutdown_n_o = 1'b1;
	end

	// Strobe stays up so that calls run back to back
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_en_o   <= 1'b1;
		wr_addr_o <= a;
		wr_data_o <= d;
	endtask : wr

	// Released lines show the inverse of the last byte
	task automatic idle;
		@(posedge clk_i);
		wr_en_o   <= 1'b0;
		wr_addr_o <= ~wr_addr_o;
		wr_data_o <= ~wr_data_o;
	endtask : idle

	task automatic pin(input logic v);
		@(posedge clk_i);
		hw_shutdown_n_o <= v;
	endtask : pin

	// Ramp channel 1 along the gamma curve
	task automatic breathe;
		for (int i = 0; i < GAMMA_STEPS / 4; i++) begin
			wr(`LPC_ADDR_PWM_FIRST, G32[i]);
			wr(`LPC_ADDR_UPDATE, `LPC_TRIGGER);
		end
	endtask : breathe
endmodule : lpc_host_model

`default_nettype wire

// ---- lpc_led_pwm_ctrl_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lpc_cfg.svh"

module lpc_led_pwm_ctrl_tb;
	localparam int         DL = 8;
	localparam int         DH = 2;
	localparam int         CH = 36;
	localparam logic [7:0] AD [3] = '{`LPC_ADDR_GLOBAL, `LPC_ADDR_FREQ,
		`LPC_ADDR_SHUTDOWN};
	localparam logic [7:0] DV [3] = '{8'h01, 8'h01, 8'h00};
	localparam int         ND [3] = '{DL, DH, DL};
	localparam int         EX [3] = '{0, DH, 0};

	logic            clk_i   = 1'b0;
	logic            reset_i = 1'b0;
	logic            wr_en;
	logic [7:0]      wr_addr;
	logic [7:0]      wr_data;
	logic            pin_n;
	logic [CH-1:0]   led;
	logic [2*CH-1:0] scale;
	logic            srst;
	int              n_fail    = 0;
	int              cmp_count = 0;
	int              skew      = 0;

	always #4 clk_i = ~clk_i;

	lpc_host_model host (.clk_i(clk_i), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
		.wr_data_o(wr_data), .hw_shutdown_n_o(pin_n));

	lpc_led_pwm_ctrl #(.CHANNELS(CH), .DIV_LO(DL), .DIV_HI(DH)) dut (
		.clk_i(clk_i), .reset_i(reset_i), .wr_en_i(wr_en),
		.wr_addr_i(wr_addr), .wr_data_i(wr_data), .hw_shutdown_n_i(pin_n),
		.led_drive_o(led), .current_scale_o(scale), .serial_if_reset_o(srst));

	// Channel 1 duty never exceeds channel 36 duty here
	always @(posedge clk_i) begin
		if (led[0] === 1'b1 && led[CH-1] !== 1'b1)
			skew <= skew + 1;
	end

	task automatic test_done;
		$display("Compares %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	task automatic chk_cnt(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			n_fail++;
			$display("Error at %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask : chk_cnt

	task automatic chk_bits(input logic [2*CH-1:0] got,
		input logic [2*CH-1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: bits %h, expected %h", $time, got, exp);
		end
	endtask : chk_bits

	// High cycles of one channel over a window
	task automatic meas(input int ch, input int n, output int hi);
		hi = 0;
		repeat (4) @(posedge clk_i);
		repeat (n) begin
			@(posedge clk_i);
			#1;
			if (led[ch] === 1'b1)
				hi++;
		end
	endtask : meas

	initial begin
		repeat (80000) @(posedge clk_i);
		n_fail++;
		test_done();
	end

	initial begin
		int hi;
		int i;
		int off;
		reset_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		#1;
		chk_bits(scale | 72'({srst, led}), 72'h0);
		host.wr(`LPC_ADDR_SHUTDOWN, 8'h01);
		host.wr(`LPC_ADDR_PWM_FIRST, 8'h80);
		host.wr(`LPC_ADDR_PWM_FIRST + 8'd35, 8'hFF);
		host.wr(`LPC_ADDR_CTRL_FIRST, 8'h01);
		host.wr(`LPC_ADDR_CTRL_FIRST + 8'd35, 8'h07);
		for (i = 1; i < 4; i++)
			host.wr(`LPC_ADDR_CTRL_FIRST + 8'(i), 8'(2 * i + 1));
		host.wr(`LPC_ADDR_UPDATE, 8'h01);
		host.idle();
		meas(0, 256 * DL, hi);
		chk_cnt(hi, 0);
		chk_bits(scale, 72'h0);
		host.wr(`LPC_ADDR_UPDATE, `LPC_TRIGGER);
		host.idle();
		repeat (3) @(posedge clk_i);
		#1;
		chk_bits(scale, {2'h3, 62'h0, 2'h3, 2'h2, 2'h1, 2'h0});
		meas(0, 256 * DL, hi);
		chk_cnt(hi, 128 * DL);
		meas(CH - 1, 256 * DL, hi);
		chk_cnt(hi, 255 * DL);
		meas(1, 256 * DL, hi);
		chk_cnt(hi, 0);
		host.breathe();
		host.idle();
		meas(0, 256 * DL, hi);
		chk_cnt(hi, 18 * DL);
		for (i = 0; i < 3; i++) begin
			host.wr(AD[i], DV[i]);
			host.idle();
			meas(0, 256 * ND[i], hi);
			chk_cnt(hi, 18 * EX[i]);
			host.wr(AD[i], DV[i] ^ 8'h01);
			host.idle();
			meas(0, 256 * DL, hi);
			chk_cnt(hi, 18 * DL);
		end
		host.wr(`LPC_ADDR_CTRL_FIRST, 8'h04);
		host.wr(`LPC_ADDR_UPDATE, `LPC_TRIGGER);
		host.idle();
		meas(0, 256 * DL, hi);
		chk_cnt(hi, 0);
		chk_bits(scale, {2'h3, 62'h0, 2'h3, 2'h2, 2'h1, 2'h2});
		host.pin(1'b0);
		host.wr(`LPC_ADDR_PWM_FIRST, 8'h40);
		host.wr(`LPC_ADDR_CTRL_FIRST, 8'h01);
		host.wr(`LPC_ADDR_UPDATE, `LPC_TRIGGER);
		host.idle();
		meas(CH - 1, 256 * DL, hi);
		chk_cnt(hi, 0);
		host.pin(1'b1);
		hi  = 0;
		off = 0;
		for (i = 1; i < 9; i++) begin
			@(posedge clk_i);
			#1;
			if (srst === 1'b1) begin
				hi++;
				off = i;
			end
		end
		chk_cnt(hi, 1);
		chk_cnt(off, 3);
		meas(0, 256 * DL, hi);
		chk_cnt(hi, 64 * DL);
		host.wr(`LPC_ADDR_RESET, 8'h01);
		host.idle();
		meas(0, 256 * DL, hi);
		chk_cnt(hi, 64 * DL);
		host.wr(`LPC_ADDR_RESET, `LPC_TRIGGER);
		host.wr(`LPC_ADDR_SHUTDOWN, 8'h01);
		host.wr(`LPC_ADDR_UPDATE, `LPC_TRIGGER);
		host.idle();
		repeat (3) @(posedge clk_i);
		#1;
		chk_bits(scale, 72'h0);
		meas(CH - 1, 256 * DL, hi);
		chk_cnt(hi, 0);
		chk_cnt(skew, 0);
		test_done();
	end
endmodule : lpc_led_pwm_ctrl_tb

`default_nettype wire
